// ### src/rar_top.sv
// The AXI4-Lite slave port and the address map were decided locally.
`timescale 1ns/1ns
`include "rar_params.svh"
module rar_top #(
	parameter int BUF_BYTES = `RAR_BUF_BYTES,
	parameter int AW        = 10
) (
	input  wire logic        REF_CLK,
	input  wire logic        RSTN,
	input  wire logic [31:0] S_AXI_AWADDR,
	input  wire logic        S_AXI_AWVALID,
	output logic             S_AXI_AWREADY,
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	input  wire logic        S_AXI_WVALID,
	output logic             S_AXI_WREADY,
	output logic [1:0]       S_AXI_BRESP,
	output logic             S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	input  wire logic [31:0] S_AXI_ARADDR,
	input  wire logic        S_AXI_ARVALID,
	output logic             S_AXI_ARREADY,
	output logic [31:0]      S_AXI_RDATA,
	output logic [1:0]       S_AXI_RRESP,
	output logic             S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY,
	input  wire logic        RX_VALID,
	input  wire logic [7:0]  RX_DATA,
	input  wire logic        RX_LAST,
	output logic             TX_VALID,
	output logic [7:0]       TX_DATA,
	output logic             TX_LAST,
	input  wire logic        TX_READY,
	input  wire logic        SIN_VALID,
	input  wire logic [7:0]  SIN_DATA,
	input  wire logic        SIN_LAST,
	output logic             SIN_READY,
	output logic             SER_VALID,
	output logic [7:0]       SER_DATA,
	output logic             SER_LAST,
	input  wire logic        SER_READY
);
	// ****************************************
	// reset release
	// ****************************************
	logic rst_s1_r, rstn_r;
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			rst_s1_r <= 1'b0;
			rstn_r   <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rstn_r   <= rst_s1_r;
		end
	end

	// ****************************************
	// register bus
	// ****************************************
	logic [`RAR_CTRL_W-1:0] ctrl_r;
	logic [31:0]            txaddr_r, rxaddr_r, status_w;
	logic                   aw_got_r, w_got_r;
	logic [31:0]            awaddr_r, wdata_r;
	logic [3:0]             wstrb_r;
	logic [15:0]            drop_cnt_r;
	logic                   ovf_r, auto_sec_r;
	rar_pkg::rar_state_t    state_r;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return res;
	endfunction : merge

	always_ff @(posedge REF_CLK or negedge rstn_r) begin
		if (!rstn_r) begin
			aw_got_r <= 1'b0; w_got_r <= 1'b0; awaddr_r <= 32'h0; wdata_r <= 32'h0; wstrb_r <= 4'h0;
			S_AXI_BVALID <= 1'b0; S_AXI_BRESP <= `RAR_RESP_OKAY;
			ctrl_r <= `RAR_CTRL_RST; txaddr_r <= `RAR_ADDR_RST; rxaddr_r <= `RAR_ADDR_RST;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_got_r <= 1'b1;
				awaddr_r <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_got_r <= 1'b1;
				wdata_r <= S_AXI_WDATA;
				wstrb_r <= S_AXI_WSTRB;
			end
			if (aw_got_r && w_got_r && !S_AXI_BVALID) begin
				aw_got_r     <= 1'b0;
				w_got_r      <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP  <= `RAR_RESP_OKAY;
				if (awaddr_r[31:8] != 24'h0) begin
					S_AXI_BRESP <= `RAR_RESP_SLVERR;
				end else if (awaddr_r[7:0] == `RAR_CTRL_OFS) begin
					ctrl_r <= `RAR_CTRL_W'(merge({27'h0, ctrl_r}, wdata_r, wstrb_r));
				end else if (awaddr_r[7:0] == `RAR_TXADDR_OFS) begin
					txaddr_r <= merge(txaddr_r, wdata_r, wstrb_r);
				end else if (awaddr_r[7:0] == `RAR_RXADDR_OFS) begin
					rxaddr_r <= merge(rxaddr_r, wdata_r, wstrb_r);
				end else if (awaddr_r[7:0] != `RAR_STATUS_OFS) begin
					S_AXI_BRESP <= `RAR_RESP_SLVERR;
				end
			end else if (S_AXI_BVALID && S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
		end
	end
	// readies stay low from acceptance until the response is taken: one write at a time
	logic aw_ready_r, w_ready_r;
	assign S_AXI_AWREADY = aw_ready_r;
	assign S_AXI_WREADY  = w_ready_r;
	always_ff @(posedge REF_CLK or negedge rstn_r) begin
		if (!rstn_r) begin
			aw_ready_r <= 1'b0;
			w_ready_r  <= 1'b0;
		end else begin
			aw_ready_r <= !aw_got_r && !(S_AXI_AWVALID && aw_ready_r) && !S_AXI_BVALID;
			w_ready_r  <= !w_got_r && !(S_AXI_WVALID && w_ready_r) && !S_AXI_BVALID;
		end
	end

	assign status_w = {drop_cnt_r, 13'h0, ovf_r, auto_sec_r, state_r != rar_pkg::S_IDLE};
	always_ff @(posedge REF_CLK or negedge rstn_r) begin
		if (!rstn_r) begin
			S_AXI_ARREADY <= 1'b0; S_AXI_RVALID <= 1'b0; S_AXI_RDATA <= 32'h0; S_AXI_RRESP <= `RAR_RESP_OKAY;
		end else begin
			S_AXI_ARREADY <= !S_AXI_RVALID && !(S_AXI_ARVALID && S_AXI_ARREADY);
			if (S_AXI_ARVALID && S_AXI_ARREADY) begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RRESP  <= `RAR_RESP_OKAY;
				if (S_AXI_ARADDR[31:8] != 24'h0) begin
					S_AXI_RDATA <= 32'h0;
					S_AXI_RRESP <= `RAR_RESP_SLVERR;
				end else if (S_AXI_ARADDR[7:0] == `RAR_CTRL_OFS) begin
					S_AXI_RDATA <= {27'h0, ctrl_r};
				end else if (S_AXI_ARADDR[7:0] == `RAR_TXADDR_OFS) begin
					S_AXI_RDATA <= txaddr_r;
				end else if (S_AXI_ARADDR[7:0] == `RAR_RXADDR_OFS) begin
					S_AXI_RDATA <= rxaddr_r;
				end else if (S_AXI_ARADDR[7:0] == `RAR_STATUS_OFS) begin
					S_AXI_RDATA <= status_w;
				end else begin
					S_AXI_RDATA <= 32'h0;
					S_AXI_RRESP <= `RAR_RESP_SLVERR;
				end
			end else if (S_AXI_RVALID && S_AXI_RREADY) begin
				S_AXI_RVALID <= 1'b0;
			end
		end
	end

	// ****************************************
	// packet engine
	// ****************************************
	logic rx_en, tx_en, rep_en, fwd_en, auto_en;
	assign rx_en   = ctrl_r[`RAR_CTRL_RXEN_BIT];
	assign tx_en   = ctrl_r[`RAR_CTRL_TXEN_BIT];
	assign rep_en  = ctrl_r[`RAR_CTRL_REP_BIT];
	assign fwd_en  = ctrl_r[`RAR_CTRL_FWD_BIT];
	assign auto_en = ctrl_r[`RAR_CTRL_AUTO_BIT];

	logic [AW:0]  len_r, idx_r, relay_start_r;
	logic [7:0]   b0_r, b1_r, rd_data;
	logic [15:0]  hdr_addr_r;
	logic [1:0]   hdr_cnt_r;
	logic         dest_r, src_sin_r, relay_pend_r, sel_sec_r;
	logic         match_p, match_s, pass_ok, slot_free, load_tx, load_ser, load_last, rd_en, sin_take;
	logic [7:0]   load_data;

	assign match_p   = {b0_r, b1_r} == rxaddr_r[15:0];
	assign match_s   = {b0_r, b1_r} == rxaddr_r[31:16];
	// a packet shorter than an address cannot carry one, so it never matches
	assign pass_ok   = !rx_en || (len_r >= (AW+1)'(`RAR_ADDR_BYTES) && (match_p || match_s));
	assign slot_free = dest_r ? (!TX_VALID || TX_READY) : (!SER_VALID || SER_READY);
	assign sin_take  = SIN_READY && SIN_VALID;
	assign rd_en     = state_r == rar_pkg::S_RD && idx_r < len_r;

	always_comb begin
		load_tx   = 1'b0;
		load_ser  = 1'b0;
		load_last = 1'b0;
		load_data = 8'h00;
		if (state_r == rar_pkg::S_HDR && hdr_cnt_r != 2'd0 && slot_free) begin
			load_tx   = 1'b1;
			load_data = hdr_cnt_r == 2'd2 ? hdr_addr_r[15:8] : hdr_addr_r[7:0];
			load_last = hdr_cnt_r == 2'd1 && !src_sin_r && idx_r >= len_r;
		end else if (state_r == rar_pkg::S_WT && slot_free) begin
			load_tx   = dest_r;
			load_ser  = !dest_r;
			load_data = rd_data;
			load_last = idx_r == len_r - (AW+1)'(1);
		end else if (state_r == rar_pkg::S_SIN && sin_take) begin
			load_tx   = 1'b1;
			load_data = SIN_DATA;
			load_last = SIN_LAST;
		end
	end

	rar_pkt_mem #(.DW(8), .DEPTH(BUF_BYTES), .AW(AW)) u_mem (
		.clk     (REF_CLK),
		.wr_en   (RX_VALID && (state_r == rar_pkg::S_IDLE || state_r == rar_pkg::S_RXD) && len_r < BUF_BYTES),
		.wr_addr (state_r == rar_pkg::S_IDLE ? AW'(0) : len_r[AW-1:0]),
		.wr_data (RX_DATA),
		.rd_en   (rd_en),
		.rd_addr (idx_r[AW-1:0]),
		.rd_data (rd_data)
	);

	always_ff @(posedge REF_CLK or negedge rstn_r) begin
		if (!rstn_r) begin
			state_r <= rar_pkg::S_IDLE; len_r <= '0; idx_r <= '0; relay_start_r <= '0;
			b0_r <= 8'h00; b1_r <= 8'h00; hdr_addr_r <= 16'h0; hdr_cnt_r <= 2'd0;
			dest_r <= 1'b0; src_sin_r <= 1'b0; relay_pend_r <= 1'b0; sel_sec_r <= 1'b0;
			auto_sec_r <= 1'b0; ovf_r <= 1'b0; drop_cnt_r <= 16'h0;
		end else begin
			case (state_r)
				rar_pkg::S_IDLE: begin
					if (RX_VALID) begin
						b0_r    <= RX_DATA;
						len_r   <= (AW+1)'(1);
						state_r <= RX_LAST ? rar_pkg::S_CHK : rar_pkg::S_RXD;
					end else if (SIN_VALID) begin
						dest_r     <= 1'b1;
						src_sin_r  <= 1'b1;
						hdr_cnt_r  <= tx_en ? 2'd2 : 2'd0;
						hdr_addr_r <= (auto_en && auto_sec_r) ? txaddr_r[31:16] : txaddr_r[15:0];
						state_r    <= rar_pkg::S_HDR;
					end
				end
				rar_pkg::S_RXD: begin
					if (RX_VALID) begin
						if (len_r == (AW+1)'(1)) begin
							b1_r <= RX_DATA;
						end
						if (len_r < BUF_BYTES) begin
							len_r <= len_r + (AW+1)'(1);
						end else begin
							ovf_r <= 1'b1; // longer packets are truncated at the buffer size
						end
						if (RX_LAST) begin
							state_r <= rar_pkg::S_CHK;
						end
					end
				end
				rar_pkg::S_CHK: begin
					if (!pass_ok) begin
						drop_cnt_r <= drop_cnt_r + 16'h1;
						state_r    <= rar_pkg::S_IDLE;
					end else begin
						// no duplicate or self-echo suppression: relayed copies reach the terminal
						sel_sec_r     <= rx_en && !match_p && match_s;
						if (auto_en && rx_en) begin
							auto_sec_r <= !match_p && match_s;
						end
						idx_r         <= (rx_en && !fwd_en) ? (AW+1)'(`RAR_ADDR_BYTES) : '0;
						relay_start_r <= rx_en ? (AW+1)'(`RAR_ADDR_BYTES) : '0;
						relay_pend_r  <= rep_en;
						dest_r        <= 1'b0;
						src_sin_r     <= 1'b0;
						hdr_cnt_r     <= 2'd0;
						state_r       <= rar_pkg::S_HDR;
					end
				end
				rar_pkg::S_HDR: begin
					if (hdr_cnt_r == 2'd0) begin
						state_r <= src_sin_r ? rar_pkg::S_SIN : rar_pkg::S_RD;
					end else if (load_tx) begin
						hdr_cnt_r <= hdr_cnt_r - 2'd1;
					end
				end
				rar_pkg::S_RD: begin
					state_r <= rar_pkg::S_WT;
				end
				rar_pkg::S_WT: begin
					if (idx_r >= len_r || load_tx || load_ser) begin
						idx_r   <= idx_r + (AW+1)'(1);
						state_r <= rar_pkg::S_RD;
						if (idx_r + (AW+1)'(1) >= len_r) begin
							if (!dest_r && relay_pend_r) begin
								relay_pend_r <= 1'b0;
								dest_r       <= 1'b1;
								idx_r        <= relay_start_r;
								hdr_cnt_r    <= tx_en ? 2'd2 : 2'd0;
								hdr_addr_r   <= (rep_en && sel_sec_r) ? txaddr_r[31:16] : txaddr_r[15:0];
								state_r      <= rar_pkg::S_HDR;
							end else begin
								state_r <= rar_pkg::S_IDLE;
							end
						end
					end
				end
				rar_pkg::S_SIN: begin
					if (sin_take && SIN_LAST) begin
						state_r <= rar_pkg::S_IDLE;
					end
				end
				default: begin
					state_r <= rar_pkg::S_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// output slots
	// ****************************************
	always_ff @(posedge REF_CLK or negedge rstn_r) begin
		if (!rstn_r) begin
			TX_VALID <= 1'b0; TX_DATA <= 8'h00; TX_LAST <= 1'b0;
			SER_VALID <= 1'b0; SER_DATA <= 8'h00; SER_LAST <= 1'b0; SIN_READY <= 1'b0;
		end else begin
			if (load_tx) begin
				TX_VALID <= 1'b1; TX_DATA <= load_data; TX_LAST <= load_last;
			end else if (TX_READY) begin
				TX_VALID <= 1'b0;
			end
			if (load_ser) begin
				SER_VALID <= 1'b1; SER_DATA <= load_data; SER_LAST <= load_last;
			end else if (SER_READY) begin
				SER_VALID <= 1'b0;
			end
			// registered ready: raised only once the transmit slot will be empty
			SIN_READY <= state_r == rar_pkg::S_SIN && !load_tx && !(sin_take && SIN_LAST) && (!TX_VALID || TX_READY);
		end
	end

	// ****************************************
	// checks
	// ****************************************
	sequence chk_drop; state_r == rar_pkg::S_CHK && !pass_ok; endsequence
	sequence chk_pass; state_r == rar_pkg::S_CHK && pass_ok; endsequence
	a_drop_nomatch: assert property (@(posedge REF_CLK) disable iff (!rstn_r)
		chk_drop |=> state_r == rar_pkg::S_IDLE && !SER_VALID) else $error("unmatched packet not dropped");
	a_strip_own: assert property (@(posedge REF_CLK) disable iff (!rstn_r)
		chk_pass and rx_en |=> relay_start_r == (AW+1)'(2)) else $error("own address not stripped");
	a_payload_only: assert property (@(posedge REF_CLK) disable iff (!rstn_r)
		chk_pass and rx_en && !fwd_en |=> idx_r == (AW+1)'(2)) else $error("address sent to terminal");
	a_secondary_use: assert property (@(posedge REF_CLK) disable iff (!rstn_r)
		state_r == rar_pkg::S_HDR && dest_r && !src_sin_r && hdr_addr_r != txaddr_r[15:0]
		|-> rep_en && sel_sec_r) else $error("secondary address misused");
	a_auto_record: assert property (@(posedge REF_CLK) disable iff (!rstn_r)
		chk_pass and auto_en && rx_en && match_s && !match_p |=> auto_sec_r) else $error("match not recorded");
	a_primary_dflt: assert property (@(posedge REF_CLK) disable iff (!rstn_r)
		state_r == rar_pkg::S_IDLE && !RX_VALID && SIN_VALID && !auto_en
		|=> hdr_addr_r == txaddr_r[15:0]) else $error("primary address not used");
	a_buffer_bound: assert property (@(posedge REF_CLK) disable iff (!rstn_r)
		len_r <= BUF_BYTES) else $error("buffer length exceeded");
	// terminal bytes are only loaded while delivering a packet that passed its check
	a_check_first: assert property (@(posedge REF_CLK) disable iff (!rstn_r)
		$rose(SER_VALID) |-> $past(state_r) == rar_pkg::S_WT && !$past(dest_r)) else $error("output before check");
	a_bvalid_hold: assert property (@(posedge REF_CLK) disable iff (!rstn_r)
		S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID) else $error("write response dropped");
endmodule : rar_top

// ### src/rar_params.svh
`ifndef RAR_PARAMS_SVH
`define RAR_PARAMS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define RAR_CTRL_OFS        32'h0000_0000
`define RAR_TXADDR_OFS      32'h0000_0004
`define RAR_RXADDR_OFS      32'h0000_0008
`define RAR_STATUS_OFS      32'h0000_000c

// ****************************************
// control fields
// ****************************************
`define RAR_CTRL_RXEN_BIT   0
`define RAR_CTRL_TXEN_BIT   1
`define RAR_CTRL_REP_BIT    2
`define RAR_CTRL_FWD_BIT    3
`define RAR_CTRL_AUTO_BIT   4
`define RAR_CTRL_W          5
`define RAR_CTRL_RST        5'h00
`define RAR_ADDR_RST        32'h0000_0000

// ****************************************
// status fields
// ****************************************
`define RAR_STAT_BUSY_BIT   0
`define RAR_STAT_SEC_BIT    1
`define RAR_STAT_OVF_BIT    2
`define RAR_STAT_DROP_LSB   16

// ****************************************
// packet layout
// ****************************************
`define RAR_ADDR_BYTES      2
`define RAR_BUF_BYTES       1024
`define RAR_RESP_OKAY       2'b00
`define RAR_RESP_SLVERR     2'b10

`endif

// ### src/rar_pkg.sv
package rar_pkg;
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_RXD  = 3'b001,
		S_CHK  = 3'b010,
		S_HDR  = 3'b011,
		S_RD   = 3'b100,
		S_WT   = 3'b101,
		S_SIN  = 3'b110
	} rar_state_t;
endpackage : rar_pkg

// ### src/rar_pkt_mem.sv
`timescale 1ns/1ns
module rar_pkt_mem #(
	parameter int DW    = 8,
	parameter int DEPTH = 1024,
	parameter int AW    = 10
) (
	input  wire logic          clk,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [DW-1:0] wr_data,
	input  wire logic          rd_en,
	input  wire logic [AW-1:0] rd_addr,
	output logic      [DW-1:0] rd_data
);
	logic [DW-1:0] mem [0:DEPTH-1];

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk) begin
		if (rd_en) begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule : rar_pkt_mem

// ### tb/rar_peer_model.sv
`timescale 1ns/1ns
// ****************************************
// radio peers and terminal on the far side
// ****************************************
module rar_peer_model (
	input  wire logic       clk,
	input  wire logic       slow,
	output logic            rx_valid,
	output logic [7:0]      rx_data,
	output logic            rx_last,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_last,
	output logic            tx_ready,
	output logic            sin_valid,
	output logic [7:0]      sin_data,
	output logic            sin_last,
	input  wire logic       sin_ready,
	input  wire logic       ser_valid,
	input  wire logic [7:0] ser_data,
	input  wire logic       ser_last,
	output logic            ser_ready
);
	logic [7:0] pend_q[$];
	logic [8:0] tx_q[$];
	logic [8:0] ser_q[$];

	initial begin
		{rx_valid, rx_last, sin_valid, sin_last} = 4'h0;
		{rx_data, sin_data} = 16'h5aa5;
		{tx_ready, ser_ready} = 2'b00;
	end

	// radio has no back-pressure: one byte per cycle, address high first
	task automatic send_rx();
		@(posedge clk);
		while (pend_q.size() > 0) begin
			rx_valid <= 1'b1;
			rx_data  <= pend_q[0];
			rx_last  <= (pend_q.size() == 1);
			void'(pend_q.pop_front());
			@(posedge clk);
		end
		rx_valid <= 1'b0;
		rx_last  <= 1'b0;
		rx_data  <= ~rx_data;
	endtask : send_rx

	task automatic send_sin();
		@(posedge clk);
		sin_valid <= 1'b1;
		while (pend_q.size() > 0) begin
			sin_data <= pend_q[0];
			sin_last <= (pend_q.size() == 1);
			void'(pend_q.pop_front());
			do @(posedge clk); while (sin_ready !== 1'b1);
		end
		sin_valid <= 1'b0;
		sin_last  <= 1'b0;
		sin_data  <= ~sin_data;
	endtask : send_sin

	// last flag kept in bit 8 so framing is compared too
	always @(posedge clk) begin
		tx_ready  <= slow ? ~tx_ready : 1'b1;
		ser_ready <= slow ? ~ser_ready : 1'b1;
		if (tx_valid && tx_ready) tx_q.push_back({tx_last, tx_data});
		if (ser_valid && ser_ready) ser_q.push_back({ser_last, ser_data});
	end
endmodule : rar_peer_model

// ### tb/rar_top_tb.sv
`timescale 1ns/1ns
`include "rar_params.svh"
module rar_top_tb;
	logic        clk, rstn, slow;
	logic [31:0] awaddr, wdata, araddr, rdata, rdat;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, resp;
	logic        rx_valid, rx_last, tx_valid, tx_last, tx_ready;
	logic        sin_valid, sin_last, sin_ready, ser_valid, ser_last, ser_ready;
	logic [7:0]  rx_data, tx_data, sin_data, ser_data;
	int          failures, n_checks;

	// small buffer so overflow is cheap to reach
	rar_top #(.BUF_BYTES(16), .AW(4)) DUT (
		.REF_CLK(clk), .RSTN(rstn),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.RX_VALID(rx_valid), .RX_DATA(rx_data), .RX_LAST(rx_last),
		.TX_VALID(tx_valid), .TX_DATA(tx_data), .TX_LAST(tx_last), .TX_READY(tx_ready),
		.SIN_VALID(sin_valid), .SIN_DATA(sin_data), .SIN_LAST(sin_last), .SIN_READY(sin_ready),
		.SER_VALID(ser_valid), .SER_DATA(ser_data), .SER_LAST(ser_last), .SER_READY(ser_ready)
	);

	rar_peer_model peer (
		.clk(clk), .slow(slow),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
		.sin_valid(sin_valid), .sin_data(sin_data), .sin_last(sin_last), .sin_ready(sin_ready),
		.ser_valid(ser_valid), .ser_data(ser_data), .ser_last(ser_last), .ser_ready(ser_ready)
	);

	initial clk = 1'b0;
	always #4 clk = ~clk;

	// ****************************************
	// bus access and compares
	// ****************************************
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge clk);
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [31:0] a);
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge clk);
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rdat = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask : rd

	task automatic chk_w(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk_w

	task automatic chk_q(ref logic [8:0] g[$], input logic [8:0] e[$]);
		chk_w(g.size(), e.size());
		if (g.size() == e.size())
			foreach (e[i]) chk_w({23'h0, g[i]}, {23'h0, e[i]});
		g = {};
	endtask : chk_q

	task automatic rd_chk(input logic [31:0] a, input logic [31:0] e, input logic [1:0] r);
		rd(a);
		chk_w(rdat, e);
		chk_w({30'h0, resp}, {30'h0, r});
	endtask : rd_chk

	// the test waits here until the engine has finished
	task automatic settle();
		repeat (3) @(posedge clk);
		do rd(`RAR_STATUS_OFS); while (rdat[`RAR_STAT_BUSY_BIT] !== 1'b0);
		repeat (4) @(posedge clk);
	endtask : settle

	task automatic rx_pkt();
		peer.send_rx();
		settle();
	endtask : rx_pkt

	task automatic sin_pkt();
		peer.send_sin();
		settle();
	endtask : sin_pkt

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : tally_and_finish

	// ****************************************
	// tests
	// ****************************************
	initial begin
		{rstn, slow, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
		{awaddr, wdata, araddr} = 96'h0;
		wstrb = 4'hf;
		failures = 0;
		n_checks = 0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		rd_chk(`RAR_CTRL_OFS, 32'h0, `RAR_RESP_OKAY);
		rd_chk(`RAR_TXADDR_OFS, `RAR_ADDR_RST, `RAR_RESP_OKAY);
		rd_chk(`RAR_RXADDR_OFS, `RAR_ADDR_RST, `RAR_RESP_OKAY);
		rd_chk(`RAR_STATUS_OFS, 32'h0, `RAR_RESP_OKAY);
		rd_chk(32'h0000_0010, 32'h0, `RAR_RESP_SLVERR);
		wr(32'h0000_0020, 32'h1);
		chk_w({30'h0, resp}, {30'h0, `RAR_RESP_SLVERR});
		wr(`RAR_STATUS_OFS, 32'hffff_ffff);
		rd_chk(`RAR_STATUS_OFS, 32'h0, `RAR_RESP_OKAY);
		$display("test regs done");
		wr(`RAR_TXADDR_OFS, 32'h5678_1234);
		wr(`RAR_RXADDR_OFS, 32'hb1b2_a1a2);
		rd_chk(`RAR_RXADDR_OFS, 32'hb1b2_a1a2, `RAR_RESP_OKAY);
		wr(`RAR_CTRL_OFS, 32'h05);
		slow <= 1'b1;
		peer.pend_q = '{8'ha1, 8'ha2, 8'hc3, 8'hd4, 8'he5};
		rx_pkt();
		chk_q(peer.ser_q, '{9'h0c3, 9'h0d4, 9'h1e5});
		chk_q(peer.tx_q, '{9'h0c3, 9'h0d4, 9'h1e5});
		wr(`RAR_CTRL_OFS, 32'h01);
		peer.pend_q = '{8'ha1, 8'ha2, 8'hf0};
		rx_pkt();
		chk_q(peer.ser_q, '{9'h1f0});
		chk_w(peer.tx_q.size(), 0);
		$display("test chain done");
		wr(`RAR_CTRL_OFS, 32'h07);
		peer.pend_q = '{8'hb1, 8'hb2, 8'h55, 8'h66};
		rx_pkt();
		chk_q(peer.ser_q, '{9'h055, 9'h166});
		chk_q(peer.tx_q, '{9'h056, 9'h078, 9'h055, 9'h166});
		slow <= 1'b0;
		peer.pend_q = '{8'ha1, 8'ha2, 8'h77};
		rx_pkt();
		chk_q(peer.ser_q, '{9'h177});
		chk_q(peer.tx_q, '{9'h012, 9'h034, 9'h177});
		peer.pend_q = '{8'h00, 8'h01, 8'h99};
		rx_pkt();
		rd(`RAR_STATUS_OFS);
		chk_w({16'h0, rdat[31:16]}, 32'h1);
		peer.pend_q = '{8'ha1};
		rx_pkt();
		rd(`RAR_STATUS_OFS);
		chk_w({16'h0, rdat[31:16]}, 32'h2);
		chk_w(peer.ser_q.size() + peer.tx_q.size(), 0);
		$display("test dual done");
		wr(`RAR_CTRL_OFS, 32'h09);
		peer.pend_q = '{8'ha1, 8'ha2, 8'h88};
		rx_pkt();
		chk_q(peer.ser_q, '{9'h0a1, 9'h0a2, 9'h188});
		wr(`RAR_CTRL_OFS, 32'h04);
		peer.pend_q = '{8'h33, 8'h44};
		rx_pkt();
		chk_q(peer.ser_q, '{9'h033, 9'h144});
		chk_q(peer.tx_q, '{9'h033, 9'h144});
		$display("test forward done");
		wr(`RAR_CTRL_OFS, 32'h02);
		peer.pend_q = '{8'h99, 8'haa};
		sin_pkt();
		chk_q(peer.tx_q, '{9'h012, 9'h034, 9'h099, 9'h1aa});
		wr(`RAR_CTRL_OFS, 32'h13);
		peer.pend_q = '{8'hb1, 8'hb2, 8'h01};
		rx_pkt();
		chk_q(peer.ser_q, '{9'h101});
		rd(`RAR_STATUS_OFS);
		chk_w({31'h0, rdat[`RAR_STAT_SEC_BIT]}, 32'h1);
		peer.pend_q = '{8'h42};
		sin_pkt();
		chk_q(peer.tx_q, '{9'h056, 9'h078, 9'h142});
		peer.pend_q = '{8'ha1, 8'ha2, 8'h02};
		rx_pkt();
		peer.pend_q = '{8'h43};
		sin_pkt();
		chk_q(peer.ser_q, '{9'h102});
		chk_q(peer.tx_q, '{9'h012, 9'h034, 9'h143});
		$display("test serial done");
		wr(`RAR_TXADDR_OFS, 32'h0001_0001);
		wr(`RAR_RXADDR_OFS, 32'h0002_0002);
		wr(`RAR_CTRL_OFS, 32'h03);
		peer.pend_q = '{8'h5a};
		sin_pkt();
		chk_q(peer.tx_q, '{9'h000, 9'h001, 9'h15a});
		peer.pend_q = '{8'h00, 8'h02, 8'h5a};
		rx_pkt();
		chk_q(peer.ser_q, '{9'h15a});
		wr(`RAR_CTRL_OFS, 32'h00);
		for (int i = 0; i < 18; i++) peer.pend_q.push_back(i[7:0]);
		rx_pkt();
		rd(`RAR_STATUS_OFS);
		chk_w({31'h0, rdat[`RAR_STAT_OVF_BIT]}, 32'h1);
		chk_w(peer.ser_q.size(), 16);
		$display("test alternate done");
		tally_and_finish();
	end

	// whole sequence needs about four hundred cycles
	initial begin
		repeat (40000) @(posedge clk);
		failures++;
		tally_and_finish();
	end
endmodule : rar_top_tb
